// ### pkg/pwc_pkg.sv
// -----------------------------------------------------------------------------
// Overview of operation
// (R1) count clock is machine clock or divided by 4..2048; other codes prohibited
// (R2) reset selects undivided clock; software picks clock before starting
// (R3) edge field: high width, rise cycle, fall cycle, all edges, low width
// (R4) mode bit clear means continuous with buffer, set means one-shot
// (R5) reset gives high width one-shot; software sets mode before starting
// (R6) enable write of one starts or restarts, zero forcibly stops
// (R7) after start nothing counts until start edge, then count from one
// (R8) rewriting one while waiting for start edge changes nothing; the code still clears a stale count left by a continuous wait
// (R9) restart during measurement clears count and waits for start edge again
// (R10) end edge with restart still sets end flag and fills buffer
// (R11) one-shot stops itself on overflow or completed measurement
// (R12) software stops continuous mode or early one-shot by writing zero
// (R13) counter clears on reset and on every enable write of one; a write that meets a start edge while waiting loads one instead
// (R14) one-shot first end edge stops and flags; coinciding restart waits instead
// (R15) continuous end edge stops, flags, then waits for next start edge
// (R16) continuous completion copies final count into result buffer
// (R17) software changes mode only while counter is stopped
// (R18) one-shot buffer read gives live count, then final result
// (R19) continuous buffer read gives last result; live count hidden
// (R20) continuous unread result overwritten sets overrun error flag
// (R21) reading result buffer clears overrun error flag
// (R22) reading result buffer clears measurement end flag
// (R23) overflow during measurement sets flag and request when enabled
// (R24) all-edge and continuous cycle modes reuse end edge as next start
// (R25) pulse input synchronised; edges found on synchronised samples
// -----------------------------------------------------------------------------
package pwc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int PRE_W = 11;

  // register offsets
  localparam logic [3:0] TIMER_CONTROL_OFF = 4'h0;
  localparam logic [3:0] TIMER_CONTROL_EXT_OFF = 4'h4;
  localparam logic [3:0] STATUS_CONTROL_OFF = 4'h8;
  localparam logic [3:0] RESULT_BUFFER_OFF = 4'hc;

  // timer_control_reg fields
  localparam int COUNTER_ENABLE_BIT = 1;
  localparam int MEASURE_MODE_BIT = 2;
  localparam int EDGE_SELECT_LSB = 8;
  localparam int CLOCK_SELECT_LSB = 12;
  // timer_control_ext_reg field
  localparam int CLOCK_SELECT_MSB_BIT = 8;
  // status_control_reg fields
  localparam int OVERFLOW_FLAG_BIT = 0;
  localparam int OVERRUN_FLAG_BIT = 1;
  localparam int END_FLAG_BIT = 2;
  localparam int OVERFLOW_IE_BIT = 4;
  localparam int END_IE_BIT = 6;
  localparam int ACTIVE_BIT = 7;

  // reset values and count constants
  localparam logic [3:0] CLOCK_SELECT_RST = 4'h0;
  localparam logic [2:0] EDGE_SELECT_RST = 3'h0;
  localparam logic MEASURE_MODE_RST = 1'b1;
  localparam logic [CNT_W-1:0] COUNT_CLEAR = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_FIRST = 16'h0001;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;

  localparam logic MODE_CONTINUOUS = 1'b0;
  localparam logic MODE_ONE_SHOT = 1'b1;

  typedef enum logic [2:0] {
    EDGE_HIGH_WIDTH = 3'b000,
    EDGE_RISE_CYCLE = 3'b001,
    EDGE_FALL_CYCLE = 3'b010,
    EDGE_ALL_EDGES = 3'b011,
    EDGE_LOW_WIDTH = 3'b100
  } edge_mode_t;

  // prescaler masks, tick when all mask bits of the free counter are set
  localparam logic [PRE_W-1:0] DIV1_MASK = 11'h000;
  localparam logic [PRE_W-1:0] DIV4_MASK = 11'h003;
  localparam logic [PRE_W-1:0] DIV16_MASK = 11'h00f;
  localparam logic [PRE_W-1:0] DIV128_MASK = 11'h07f;
  localparam logic [PRE_W-1:0] DIV256_MASK = 11'h0ff;
  localparam logic [PRE_W-1:0] DIV512_MASK = 11'h1ff;
  localparam logic [PRE_W-1:0] DIV1024_MASK = 11'h3ff;
  localparam logic [PRE_W-1:0] DIV2048_MASK = 11'h7ff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_MEAS = 2'b10
  } pwc_state_t;
endpackage

// ### logic/pulse_width_capture_timer.sv
`timescale 1ns/10ps
module pulse_width_capture_timer
  import pwc_pkg::*;
(
  input wire logic clk_sys, // machine clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [ADDR_W-1:0] addr, // register byte address
  input wire logic [DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [DATA_W-1:0] rd_data, // read data, cycle after strobe
  input wire logic pulse_in, // external pulse, asynchronous
  output logic overflow_irq, // overflow request, level
  output logic measure_end_irq, // measurement end request, level
  output logic measure_active // counter enable state
);

  // ---------------------------------------------------------------------------
  // input synchroniser and edge detect
  // ---------------------------------------------------------------------------
  logic sync1_reg, sync2_reg, prev_reg;
  logic sync1_next, sync2_next, prev_next;
  logic rise, fall;

  always_comb begin
    sync1_next = pulse_in;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // (R25) two-stage sync
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // (R25) edges from synced samples
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  logic enable_reg, enable_next;
  logic mode_reg, mode_next;
  logic [2:0] edge_sel_reg, edge_sel_next;
  logic [3:0] clk_sel_reg, clk_sel_next;
  logic ovf_ie_reg, ovf_ie_next;
  logic end_ie_reg, end_ie_next;

  logic ctrl_wr, ext_wr, stat_wr, buf_rd;
  logic start_cmd, stop_cmd;

  assign ctrl_wr = wr_en && (addr == TIMER_CONTROL_OFF);
  assign ext_wr = wr_en && (addr == TIMER_CONTROL_EXT_OFF);
  assign stat_wr = wr_en && (addr == STATUS_CONTROL_OFF);
  assign buf_rd = rd_en && (addr == RESULT_BUFFER_OFF);
  // (R6) one starts or restarts, zero stops
  assign start_cmd = ctrl_wr && wr_data[COUNTER_ENABLE_BIT];
  assign stop_cmd = ctrl_wr && !wr_data[COUNTER_ENABLE_BIT];

  // ---------------------------------------------------------------------------
  // count clock prescaler
  // ---------------------------------------------------------------------------
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [PRE_W-1:0] div_mask;
  logic div_legal;
  logic tick;
  logic pre_restart;

  // (R1) count clock select decode
  always_comb begin
    div_mask = DIV1_MASK;
    div_legal = 1'b1;
    unique case (clk_sel_reg)
      4'h0: div_mask = DIV1_MASK;
      4'h1: div_mask = DIV4_MASK;
      4'h2: div_mask = DIV16_MASK;
      4'h3: div_mask = DIV128_MASK;
      4'h4: div_mask = DIV256_MASK;
      4'h8: div_mask = DIV512_MASK;
      4'h9: div_mask = DIV1024_MASK;
      4'ha: div_mask = DIV2048_MASK;
      // prohibited codes freeze the count rather than guess a rate
      default: div_legal = 1'b0;
    endcase
  end

  assign tick = div_legal && ((pre_reg & div_mask) == div_mask);

  always_comb begin
    pre_next = pre_reg + 11'h001;
    if (pre_restart) begin
      pre_next = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ---------------------------------------------------------------------------
  // edge selection
  // ---------------------------------------------------------------------------
  logic start_edge, end_edge, end_restarts;

  // (R3) edge mode decode
  always_comb begin
    start_edge = 1'b0;
    end_edge = 1'b0;
    end_restarts = 1'b0;
    unique case (edge_sel_reg)
      EDGE_HIGH_WIDTH: begin
        start_edge = rise;
        end_edge = fall;
      end
      EDGE_RISE_CYCLE: begin
        start_edge = rise;
        end_edge = rise;
        end_restarts = 1'b1;
      end
      EDGE_FALL_CYCLE: begin
        start_edge = fall;
        end_edge = fall;
        end_restarts = 1'b1;
      end
      EDGE_ALL_EDGES: begin
        start_edge = rise | fall;
        end_edge = rise | fall;
        end_restarts = 1'b1;
      end
      EDGE_LOW_WIDTH: begin
        start_edge = fall;
        end_edge = rise;
      end
      // prohibited codes never see an edge
      default: begin
        start_edge = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // measurement engine
  // ---------------------------------------------------------------------------
  pwc_state_t state_reg, state_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic [CNT_W-1:0] result_reg, result_next;
  logic fresh_reg, fresh_next;
  logic ovf_flag_reg, ovf_flag_next;
  logic err_flag_reg, err_flag_next;
  logic end_flag_reg, end_flag_next;
  logic ovf_set, err_set, end_set;
  logic ovf_clr, err_clr, end_clr;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    result_next = result_reg;
    fresh_next = fresh_reg;
    enable_next = enable_reg;
    mode_next = mode_reg;
    edge_sel_next = edge_sel_reg;
    clk_sel_next = clk_sel_reg;
    ovf_ie_next = ovf_ie_reg;
    end_ie_next = end_ie_reg;
    ovf_set = 1'b0;
    err_set = 1'b0;
    end_set = 1'b0;
    pre_restart = 1'b0;

    if (state_reg == ST_MEAS) begin
      if (end_edge) begin
        end_set = 1'b1;
        if (mode_reg == MODE_CONTINUOUS) begin
          // (R16) copy final count
          result_next = count_reg;
          fresh_next = 1'b1;
          // (R20) unread result overwritten
          err_set = fresh_reg;
          if (end_restarts) begin
            // (R24) end edge doubles as start
            count_next = COUNT_FIRST;
            pre_restart = 1'b1;
          end else begin
            // (R15) wait for next start
            state_next = ST_WAIT;
          end
        end else begin
          // (R14) one-shot done
          state_next = ST_IDLE;
          enable_next = 1'b0;
        end
      end else if (tick) begin
        count_next = count_reg + 16'h0001;
        if (count_reg == COUNT_MAX) begin
          // (R23) overflow flag
          ovf_set = 1'b1;
          if (mode_reg == MODE_ONE_SHOT) begin
            // (R11) self stop on overflow
            state_next = ST_IDLE;
            enable_next = 1'b0;
          end
        end
      end
    end else if ((state_reg == ST_WAIT) && start_edge) begin
      // (R7) first count is one
      count_next = COUNT_FIRST;
      state_next = ST_MEAS;
      pre_restart = 1'b1;
    end

    // a read that meets a new result leaves that result unread
    if (buf_rd && !end_set) begin
      fresh_next = 1'b0;
    end

    if (ctrl_wr) begin
      mode_next = wr_data[MEASURE_MODE_BIT];
      edge_sel_next = wr_data[EDGE_SELECT_LSB +: 3];
      clk_sel_next[2:0] = wr_data[CLOCK_SELECT_LSB +: 3];
    end
    if (ext_wr) begin
      clk_sel_next[3] = wr_data[CLOCK_SELECT_MSB_BIT];
    end
    if (stat_wr) begin
      ovf_ie_next = wr_data[OVERFLOW_IE_BIT];
      end_ie_next = wr_data[END_IE_BIT];
    end

    if (start_cmd) begin
      enable_next = 1'b1;
      // (R8) rewrite while waiting keeps the wait state and the prescaler
      if (state_reg != ST_WAIT) begin
        // (R13) clear on start
        count_next = COUNT_CLEAR;
        // (R9) restart waits for edge again
        state_next = ST_WAIT;
        pre_restart = 1'b1;
      end else if (!start_edge) begin
        // (R13) stale count from continuous wait clears too
        count_next = COUNT_CLEAR;
      end
    end else if (stop_cmd) begin
      // (R12) forced stop
      enable_next = 1'b0;
      state_next = ST_IDLE;
    end
  end

  // (R21) (R22) buffer read clears overrun and end flags, flag writes of zero clear all three
  assign ovf_clr = stat_wr && !wr_data[OVERFLOW_FLAG_BIT];
  assign err_clr = buf_rd || (stat_wr && !wr_data[OVERRUN_FLAG_BIT]);
  assign end_clr = buf_rd || (stat_wr && !wr_data[END_FLAG_BIT]);

  // (R10) set beats clear, so a coinciding restart keeps the end flag
  always_comb begin
    ovf_flag_next = ovf_set | (ovf_flag_reg & ~ovf_clr);
    err_flag_next = err_set | (err_flag_reg & ~err_clr);
    end_flag_next = end_set | (end_flag_reg & ~end_clr);
  end

  // (R2) (R5) reset defaults
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= COUNT_CLEAR;
      result_reg <= COUNT_CLEAR;
      fresh_reg <= 1'b0;
      enable_reg <= 1'b0;
      mode_reg <= MEASURE_MODE_RST;
      edge_sel_reg <= EDGE_SELECT_RST;
      clk_sel_reg <= CLOCK_SELECT_RST;
      ovf_ie_reg <= 1'b0;
      end_ie_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
      end_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      result_reg <= result_next;
      fresh_reg <= fresh_next;
      enable_reg <= enable_next;
      mode_reg <= mode_next;
      edge_sel_reg <= edge_sel_next;
      clk_sel_reg <= clk_sel_next;
      ovf_ie_reg <= ovf_ie_next;
      end_ie_reg <= end_ie_next;
      ovf_flag_reg <= ovf_flag_next;
      err_flag_reg <= err_flag_next;
      end_flag_reg <= end_flag_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read path and outputs
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_next;
  logic ovf_irq_next, end_irq_next;

  always_comb begin
    rd_data_next = '0;
    if (rd_en) begin
      unique case (addr)
        TIMER_CONTROL_OFF: begin
          rd_data_next[COUNTER_ENABLE_BIT] = enable_reg;
          rd_data_next[MEASURE_MODE_BIT] = mode_reg;
          rd_data_next[EDGE_SELECT_LSB +: 3] = edge_sel_reg;
          rd_data_next[CLOCK_SELECT_LSB +: 3] = clk_sel_reg[2:0];
        end
        TIMER_CONTROL_EXT_OFF: begin
          rd_data_next[CLOCK_SELECT_MSB_BIT] = clk_sel_reg[3];
        end
        STATUS_CONTROL_OFF: begin
          rd_data_next[OVERFLOW_FLAG_BIT] = ovf_flag_reg;
          rd_data_next[OVERRUN_FLAG_BIT] = err_flag_reg;
          rd_data_next[END_FLAG_BIT] = end_flag_reg;
          rd_data_next[OVERFLOW_IE_BIT] = ovf_ie_reg;
          rd_data_next[END_IE_BIT] = end_ie_reg;
          rd_data_next[ACTIVE_BIT] = (state_reg == ST_MEAS);
        end
        RESULT_BUFFER_OFF: begin
          // (R4) (R18) (R19) one-shot shows the counter, continuous the buffer
          if (mode_reg == MODE_ONE_SHOT) begin
            rd_data_next = count_reg;
          end else begin
            rd_data_next = result_reg;
          end
        end
        // unmapped addresses read zero
        default: rd_data_next = '0;
      endcase
    end
  end

  // (R23) request gated by enable
  always_comb begin
    ovf_irq_next = ovf_flag_next & ovf_ie_next;
    end_irq_next = end_flag_next & end_ie_next;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
      overflow_irq <= 1'b0;
      measure_end_irq <= 1'b0;
      measure_active <= 1'b0;
    end else begin
      rd_data <= rd_data_next;
      overflow_irq <= ovf_irq_next;
      measure_end_irq <= end_irq_next;
      measure_active <= enable_next;
    end
  end

endmodule

// ### dv/pwc_properties.sv
`timescale 1ns/10ps
module pwc_properties
  import pwc_pkg::*;
(
  input wire logic clk_sys, // machine clock
  input wire logic arst_n, // async reset
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic [DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [DATA_W-1:0] rd_data, // read data
  input wire logic pulse_in, // pulse input
  input wire logic overflow_irq, // overflow request
  input wire logic measure_end_irq, // end request
  input wire logic measure_active // running
);
  logic [4:0] hist_reg;
  logic [4:0] hist_next;
  logic quiet;
  logic ctl_wr;
  logic buf_rd;

  // quiet: no pulse edge can reach the detector in the next two cycles
  always_comb begin
    hist_next = {hist_reg[3:0], pulse_in};
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hist_reg <= 5'h00;
    end else begin
      hist_reg <= hist_next;
    end
  end
  assign quiet = (&{hist_reg, pulse_in}) | ~(|{hist_reg, pulse_in});
  assign ctl_wr = wr_en && addr == TIMER_CONTROL_OFF;
  assign buf_rd = rd_en && addr == RESULT_BUFFER_OFF;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_START: assert property (ctl_wr && wr_data[COUNTER_ENABLE_BIT] |=> measure_active)
    else $error("enable write did not start");
  AST_STOP: assert property (ctl_wr && !wr_data[COUNTER_ENABLE_BIT] |=> !measure_active)
    else $error("zero write did not stop");
  AST_NO_SELF_START: assert property ($rose(measure_active) |-> $past(ctl_wr && wr_data[1]))
    else $error("started without enable write");
  AST_RESTART_CLEAR: assert property (
    ctl_wr && wr_data[COUNTER_ENABLE_BIT] && wr_data[MEASURE_MODE_BIT] && quiet
    ##1 buf_rd && quiet |=> rd_data == COUNT_CLEAR)
    else $error("count not cleared by start");
  AST_END_CLEAR: assert property (buf_rd && quiet |-> ##2 !measure_end_irq)
    else $error("end flag kept after buffer read");
  AST_END_SRC: assert property (
    $rose(measure_end_irq) && !$past(wr_en) |-> $past(measure_active, 2))
    else $error("end flag set while stopped");
  AST_OVF_SRC: assert property (
    $rose(overflow_irq) && !$past(wr_en) |-> $past(measure_active, 2))
    else $error("overflow flag set while stopped");
  AST_END_FLAG_SEEN: assert property (
    rd_en && addr == STATUS_CONTROL_OFF && measure_end_irq && !$past(wr_en || buf_rd)
    |=> rd_data[END_FLAG_BIT])
    else $error("end flag missing in status");

  COV_END: cover property ($rose(measure_end_irq));
  COV_OVF: cover property ($rose(overflow_irq));
  COV_BUF: cover property (buf_rd ##1 rd_data != COUNT_CLEAR);
endmodule

// ### dv/pulse_source.sv
`timescale 1ns/10ps
module pulse_source (
  output logic pulse_in, // pulse under measurement
  input wire logic clk_sys // machine clock
);
  initial pulse_in = 1'b0;
  // level changes at a clock edge; the two-stage synchroniser absorbs it
  task automatic level(input logic lvl, input int cyc);
    @(posedge clk_sys);
    pulse_in <= lvl;
    repeat (cyc - 1) @(posedge clk_sys);
  endtask
endmodule

// ### dv/pulse_width_capture_timer_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pulse_width_capture_timer_tb
  import pwc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic pulse_in;
  logic overflow_irq;
  logic measure_end_irq;
  logic measure_active;
  logic [DATA_W-1:0] v;
  int miscompares = 0;
  int compares = 0;

  pulse_width_capture_timer u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pulse_in(pulse_in), .overflow_irq(overflow_irq),
    .measure_end_irq(measure_end_irq), .measure_active(measure_active));
  pulse_source u_src (.pulse_in(pulse_in), .clk_sys(clk_sys));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // bus tasks, entered at a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    // a strobe being lowered in this step must see one low cycle first
    if (wr_en === 1'b1) @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
    @(posedge clk_sys);
  endtask

  task automatic t_reset();
    rd(TIMER_CONTROL_OFF);
    `CHK(v, 16'h0004)
    rd(TIMER_CONTROL_EXT_OFF);
    `CHK(v, 16'h0000)
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0000)
    rd(RESULT_BUFFER_OFF);
    `CHK(v, COUNT_CLEAR)
    wr(4'h2, 16'h0002);
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0000)
  endtask

  task automatic t_div();
    logic [3:0] code [4] = '{4'h0, 4'h1, 4'h2, 4'h8};
    int hi [4] = '{20, 42, 70, 1100};
    logic [15:0] exp [4] = '{16'd20, 16'd11, 16'd5, 16'd3};
    for (int i = 0; i < 4; i++) begin
      wr(TIMER_CONTROL_EXT_OFF, {7'h00, code[i][3], 8'h00});
      wr(TIMER_CONTROL_OFF, {1'b0, code[i][2:0], 9'h000, 3'b110});
      wr(TIMER_CONTROL_OFF, {1'b0, code[i][2:0], 9'h000, 3'b110});
      u_src.level(1'b1, hi[i]);
      u_src.level(1'b0, 10);
      rd(RESULT_BUFFER_OFF);
      `CHK(v, exp[i])
      `CHK(measure_active, 1'b0)
    end
  endtask

  task automatic t_edges();
    logic [15:0] exp [8] = '{16'd8, 16'd20, 16'd20, 16'd8, 16'd12, 16'd0, 16'd0, 16'd0};
    wr(TIMER_CONTROL_EXT_OFF, 16'h0000);
    wr(STATUS_CONTROL_OFF, 16'h0040);
    for (int i = 0; i < 8; i++) begin
      wr(TIMER_CONTROL_OFF, {5'h00, i[2:0], 8'h06});
      repeat (3) begin
        u_src.level(1'b1, 8);
        u_src.level(1'b0, 12);
      end
      `CHK(measure_end_irq, (i < 5))
      rd(RESULT_BUFFER_OFF);
      `CHK(v, exp[i])
      wr(TIMER_CONTROL_OFF, 16'h0000);
    end
  endtask

  task automatic t_restart();
    wr(TIMER_CONTROL_OFF, 16'h0006);
    fork
      u_src.level(1'b1, 30);
      begin
        repeat (12) @(posedge clk_sys);
        wr(TIMER_CONTROL_OFF, 16'h0006);
        rd(RESULT_BUFFER_OFF);
      end
    join
    `CHK(v, COUNT_CLEAR)
    u_src.level(1'b0, 10);
    u_src.level(1'b1, 12);
    u_src.level(1'b0, 10);
    rd(RESULT_BUFFER_OFF);
    `CHK(v, 16'd12)
    u_src.level(1'b1, 5);
    u_src.level(1'b0, 10);
    rd(RESULT_BUFFER_OFF);
    `CHK(v, 16'd12)
  endtask

  task automatic t_cont();
    wr(STATUS_CONTROL_OFF, 16'h0040);
    wr(TIMER_CONTROL_OFF, 16'h0002);
    u_src.level(1'b1, 10);
    u_src.level(1'b0, 10);
    u_src.level(1'b1, 15);
    u_src.level(1'b0, 10);
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0046)
    rd(RESULT_BUFFER_OFF);
    `CHK(v, 16'd15)
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0040)
    fork
      u_src.level(1'b1, 9);
      begin
        repeat (5) @(posedge clk_sys);
        rd(RESULT_BUFFER_OFF);
        `CHK(v, 16'd15)
        rd(STATUS_CONTROL_OFF);
      end
    join
    `CHK(v, 16'h00c0)
    u_src.level(1'b0, 10);
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0044)
    rd(RESULT_BUFFER_OFF);
    `CHK(v, 16'd9)
    wr(TIMER_CONTROL_OFF, 16'h0000);
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0040)
  endtask

  // one-shot overflow: the longest case, about 65k cycles at the undivided clock
  task automatic t_ovf();
    wr(STATUS_CONTROL_OFF, 16'h0010);
    wr(TIMER_CONTROL_OFF, 16'h0006);
    u_src.level(1'b1, 65600);
    `CHK(overflow_irq, 1'b1)
    `CHK(measure_active, 1'b0)
    u_src.level(1'b0, 10);
    rd(STATUS_CONTROL_OFF);
    `CHK(v, 16'h0011)
  endtask

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_div();
    t_edges();
    t_restart();
    t_cont();
    t_ovf();
    results();
  end

  initial begin
    #900000;
    miscompares++;
    results();
  end
endmodule

bind pulse_width_capture_timer pwc_properties u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .pulse_in(pulse_in), .overflow_irq(overflow_irq),
  .measure_end_irq(measure_end_irq), .measure_active(measure_active));
